// ==== phy_lc_pkg.sv ====
// constants, types and coding functions for the line coding block
package phy_lc_pkg;
  typedef enum logic [1:0] {SPD_10 = 2'h0, SPD_100 = 2'h1, SPD_1000 = 2'h2} speed_t;
  localparam int SCR_W = 11;
  localparam logic [10:0] SCR_SEED = 11'h7FF;
  localparam int CODE_W = 5;
  localparam logic [4:0] IDLE_CODE = 5'h1F;
  localparam logic [1:0] DSCR_LOCK_LAST = 2'h2;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] PRE_BYTE_INV = 8'hAA;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [2:0] PRE_BYTES = 3'h7;
  localparam int SYS_PERIOD_NS = 5;
  localparam int RX10_CLK_NS = 400;
  localparam int RX10_HALF = RX10_CLK_NS / (2 * SYS_PERIOD_NS);
  localparam int G_LFSR_W = 16;
  localparam logic [15:0] G_RST = 16'h0001;
  localparam int STRAP_W = 3;
  localparam int ADDR_W = 5;
  localparam int LVL_W = 3;
  localparam int SMP_W = 8;
  localparam int SYM_W = 9;
  localparam int PAM_BASE = 5;
  localparam int PAM_OFS = 2;
  localparam logic signed [2:0] LVL_P1 = 3'sh1;
  localparam logic signed [2:0] LVL_P2 = 3'sh2;
  // marker levels D,C,B,A; decodes above 511 so no data symbol can mimic it
  localparam logic [11:0] MARK_LVLS = {LVL_P2, LVL_P1, LVL_P1, LVL_P2};
  localparam int SLICE_HI = 48;
  localparam int SLICE_LO = 16;

  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    case (n)
      4'h0: enc4b5b = 5'h1E;
      4'h1: enc4b5b = 5'h09;
      4'h2: enc4b5b = 5'h14;
      4'h3: enc4b5b = 5'h15;
      4'h4: enc4b5b = 5'h0A;
      4'h5: enc4b5b = 5'h0B;
      4'h6: enc4b5b = 5'h0E;
      4'h7: enc4b5b = 5'h0F;
      4'h8: enc4b5b = 5'h12;
      4'h9: enc4b5b = 5'h13;
      4'hA: enc4b5b = 5'h16;
      4'hB: enc4b5b = 5'h17;
      4'hC: enc4b5b = 5'h1A;
      4'hD: enc4b5b = 5'h1B;
      4'hE: enc4b5b = 5'h1C;
      default: enc4b5b = 5'h1D;
    endcase
  endfunction

  // x^11+x^9+1, five bits per code group; returns {next state, key}
  function automatic logic [15:0] scr5(input logic [10:0] s);
    logic [10:0] t;
    logic [4:0] k;
    t = s;
    k = 5'h00;
    for (int i = 0; i < 5; i++) begin
      k[4-i] = t[10] ^ t[8];
      t = {t[9:0], k[4-i]};
    end
    return {t, k};
  endfunction

  // x^16+x^14+x^13+x^11+1, a byte per symbol; returns {next state, key}
  function automatic logic [23:0] g_step(input logic [15:0] s);
    logic [15:0] t;
    logic b;
    t = s;
    for (int i = 0; i < 8; i++) begin
      b = t[15] ^ t[13] ^ t[12] ^ t[10];
      t = {t[14:0], b};
    end
    return {t, t[7:0]};
  endfunction

  // nonzero and one to one in the address
  function automatic logic [15:0] seed_of(input logic [4:0] a);
    return {a, ~a, a, 1'b1};
  endfunction

  function automatic logic [11:0] pam_enc(input logic [8:0] v);
    int n;
    logic [11:0] r;
    n = int'(v);
    r = 12'h000;
    for (int d = 0; d < 4; d++) begin
      r[d*3 +: 3] = 3'(n % PAM_BASE - PAM_OFS);
      n = n / PAM_BASE;
    end
    return r;
  endfunction

  function automatic logic [8:0] pam_dec(input logic [11:0] l);
    int n;
    n = 0;
    for (int d = 3; d >= 0; d--) begin
      n = n * PAM_BASE + int'($signed(l[d*3 +: 3])) + PAM_OFS;
    end
    return 9'(n);
  endfunction
endpackage

// ==== lc_stream_if.sv ====
// valid/ready byte stream between the block's own modules
`timescale 1ns/1ps
`default_nettype none
interface lc_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ==== lc_skid_fifo.sv ====
// small valid/ready buffer; a stalled receiver loses no word
`timescale 1ns/1ps
`default_nettype none
module lc_skid_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // streams
  lc_stream_if.snk s_in,
  lc_stream_if.src s_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign s_in.ready = cnt_q != (AW+1)'(DEPTH);
  assign s_out.valid = cnt_q != '0;
  assign s_out.data = mem_q[rp_q];
  assign push = s_in.valid && s_in.ready;
  assign pop = s_out.valid && s_out.ready;

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = s_in.data;
      wp_d = (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ==== lc_xtalk_cancel.sv ====
// echo and near-end crosstalk removal plus slicing, all four channels
`timescale 1ns/1ps
`default_nettype none
module lc_xtalk_cancel
  import phy_lc_pkg::*;
#(
  parameter int ECHO_K = 4,
  parameter int NEXT_K = 2
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // samples and own transmit levels
  input wire logic signed [SMP_W-1:0] i_smp [4],
  input wire logic signed [LVL_W-1:0] i_own [4],
  // sliced levels
  output logic signed [LVL_W-1:0] o_lvl [4]
);
  logic signed [LVL_W-1:0] lvl_d [4];
  int y;

  always_comb begin
    y = 0;
    for (int i = 0; i < 4; i++) begin
      // digital echo of own channel
      y = int'(i_smp[i]) - ECHO_K * int'(i_own[i]);
      // one canceler per foreign channel, three in all
      for (int j = 0; j < 4; j++) begin
        if (j != i) y = y - NEXT_K * int'(i_own[j]);
      end
      if (y > SLICE_HI) lvl_d[i] = LVL_P2;
      else if (y > SLICE_LO) lvl_d[i] = LVL_P1;
      else if (y > -SLICE_LO) lvl_d[i] = 3'sh0;
      else if (y > -SLICE_HI) lvl_d[i] = -LVL_P1;
      else lvl_d[i] = -LVL_P2;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 4; i++) o_lvl[i] <= 3'sh0;
    end else begin
      o_lvl <= lvl_d;
    end
  end
endmodule
`default_nettype wire

// ==== phy_line_coding_crossover.sv ====
// line coding, receive alignment and pair mapping of a triple speed phy
// Contract
// - 100 mode: 11-bit scrambler, only then
// - sequence 2047 long; descrambler regenerates it
// - scramble after 4B/5B conversion
// - 10 mode: drop seven preamble bytes
// - 10 mode receive clock runs while idle
// - decode only after squelch qualifies input
// - detect and fix reversed 10 receive polarity
// - gig slave transmits on recovered clock
// - gig: all four pairs both ways
// - three crosstalk cancelers per receive channel
// - digital echo canceler after hybrid
// - gig: byte to 9-bit to 4D-PAM5
// - gig scrambler seed from management address
// - address low bits straps, top two zero
// - resolve seed, skew, order, polarity first
// - then PAM5 to 9-bit, descramble to byte
// - auto crossover follows partner's mapping
// - 10/100: A,B swap by mapping; gig: all; gig here ignores o_crossed, receive sorts A,B and C,D itself
// - auto crossover on after reset; disable bit
// - disabled: crossover select picks the mapping
`timescale 1ns/1ps
`default_nettype none
module phy_line_coding_crossover
  import phy_lc_pkg::*;
#(
  parameter int SKEW_MAX = 8,
  parameter int MARK_GAP = 8
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // mode, straps, crossover control
  input wire logic [1:0] i_speed,
  input wire logic i_gig_slave,
  input wire logic [STRAP_W-1:0] i_mgmt_addr_straps,
  input wire logic i_xover_disable,
  input wire logic i_crossover_select,
  input wire logic i_partner_crossed,
  // 100 transmit and receive code groups
  input wire logic [3:0] i_tx_nib,
  input wire logic i_tx_en,
  output logic [CODE_W-1:0] o_tx_code,
  input wire logic [CODE_W-1:0] i_rx_code,
  input wire logic i_rx_code_idle,
  output logic [CODE_W-1:0] o_rx_code,
  output logic o_rx_locked,
  // 10 receive bytes
  input wire logic i_squelch_ok,
  input wire logic i_rx10_active,
  input wire logic [7:0] i_rx10_byte,
  input wire logic i_rx10_valid,
  output logic o_rx10_in_ready,
  output logic [7:0] o_rx10_data,
  output logic o_rx10_valid,
  input wire logic i_rx10_ready,
  output logic o_rx10_clk,
  output logic o_rx10_pol_inv,
  // gig data
  input wire logic [7:0] i_gtx_byte,
  input wire logic i_gtx_valid,
  input wire logic signed [SMP_W-1:0] i_rx_smp [4],
  output logic [7:0] o_grx_byte,
  output logic o_grx_valid,
  output logic o_grx_locked,
  // line side
  input wire logic signed [LVL_W-1:0] i_fe_tx_lvl,
  output logic signed [LVL_W-1:0] o_fe_rx_lvl,
  output logic signed [LVL_W-1:0] o_line_pair_a,
  output logic signed [LVL_W-1:0] o_line_pair_b,
  output logic signed [LVL_W-1:0] o_line_pair_c,
  output logic signed [LVL_W-1:0] o_line_pair_d,
  output logic [3:0] o_pair_active,
  output logic o_crossed,
  output logic o_tx_clk_recovered
);
  localparam int SKW = $clog2(SKEW_MAX);
  localparam int MGW = $clog2(MARK_GAP);
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_PRE = 2'b01, R_DATA = 2'b11} rx10_st_t;
  typedef enum logic [1:0] {A_SEEK = 2'b00, A_SEED = 2'b01, A_LOCK = 2'b11} align_st_t;

  speed_t spd;
  logic sq_m, sq_s, px_m, px_s;
  assign spd = speed_t'(i_speed);

  // pins from outside the clock domain
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sq_m <= 1'b0;
      sq_s <= 1'b0;
      px_m <= 1'b0;
      px_s <= 1'b0;
    end else begin
      sq_m <= i_squelch_ok;
      sq_s <= sq_m;
      px_m <= i_partner_crossed;
      px_s <= px_m;
    end
  end

  // straps caught on the first edge after release
  logic cap_q, cap_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [G_LFSR_W-1:0] glt_q, glt_d;
  logic [MGW-1:0] mg_q, mg_d;
  logic [11:0] tlv_q, tlv_d;
  logic [23:0] gt;
  logic [SYM_W-1:0] tsym;

  always_comb begin
    cap_d = 1'b1;
    addr_d = addr_q;
    glt_d = glt_q;
    mg_d = mg_q;
    tlv_d = 12'h000;
    gt = g_step(glt_q);
    tsym = {~i_gtx_valid, (i_gtx_valid ? i_gtx_byte : 8'h00) ^ gt[7:0]};
    if (!cap_q) begin
      addr_d = {2'b00, i_mgmt_addr_straps};
      glt_d = seed_of({2'b00, i_mgmt_addr_straps});
    end else if (spd == SPD_1000) begin
      mg_d = (i_gtx_valid || mg_q == MGW'(MARK_GAP-1)) ? '0 : mg_q + 1'b1;
      if (!i_gtx_valid && mg_q == '0) begin
        // alignment marker; scrambler holds so the partner can stay in step
        tlv_d = MARK_LVLS;
      end else begin
        tlv_d = pam_enc(tsym);
        glt_d = gt[23:8];
      end
    end
  end

  // 100 mode scrambler and descrambler
  logic [SCR_W-1:0] scr_q, scr_d, dsc_q, dsc_d;
  logic [15:0] sc, dk;
  logic [CODE_W-1:0] txc_d, rxc_d;
  logic [1:0] dcnt_q, dcnt_d;
  logic dlk_q, dlk_d;

  always_comb begin
    sc = scr5(scr_q);
    dk = scr5(dsc_q);
    scr_d = scr_q;
    txc_d = '0;
    dsc_d = dsc_q;
    dcnt_d = dcnt_q;
    dlk_d = dlk_q;
    rxc_d = IDLE_CODE;
    if (spd == SPD_100) begin
      scr_d = sc[15:5];
      txc_d = (i_tx_en ? enc4b5b(i_tx_nib) : IDLE_CODE) ^ sc[4:0];
      if (!dlk_q) begin
        // idle groups reveal the key; three fill the 11-bit state
        if (i_rx_code_idle) begin
          dsc_d = {dsc_q[5:0], i_rx_code ^ IDLE_CODE};
          dcnt_d = dcnt_q + 1'b1;
          dlk_d = dcnt_q == DSCR_LOCK_LAST;
        end
      end else begin
        dsc_d = dk[15:5];
        rxc_d = i_rx_code ^ dk[4:0];
      end
    end else begin
      dcnt_d = 2'h0;
      dlk_d = 1'b0;
    end
  end

  // 10 mode receive framing
  rx10_st_t r_q, r_d;
  logic [2:0] pc_q, pc_d;
  logic pol_q, pol_d;
  logic [RX10_HALF > 1 ? $clog2(RX10_HALF)-1 : 0 : 0] dv_q, dv_d;
  logic rck_q, rck_d;
  logic [7:0] rb;
  logic push;
  lc_stream_if #(.W(8)) rx_in ();
  lc_stream_if #(.W(8)) rx_out ();

  always_comb begin
    r_d = r_q;
    pc_d = pc_q;
    pol_d = pol_q;
    push = 1'b0;
    rb = pol_q ? ~i_rx10_byte : i_rx10_byte;
    // free running so the mac never loses its clock in gaps
    dv_d = (dv_q == $bits(dv_q)'(RX10_HALF-1)) ? '0 : dv_q + 1'b1;
    rck_d = (dv_q == $bits(dv_q)'(RX10_HALF-1)) ? ~rck_q : rck_q;
    case (r_q)
      R_IDLE: begin
        pc_d = 3'h0;
        if (spd == SPD_10 && sq_s && i_rx10_active) r_d = R_PRE;
      end
      R_PRE: begin
        if (i_rx10_valid && rx_in.ready) begin
          if (pc_q == 3'h0) begin
            pol_d = i_rx10_byte == PRE_BYTE_INV;
            rb = pol_d ? ~i_rx10_byte : i_rx10_byte;
          end
          if (rb == SFD_BYTE) begin
            push = 1'b1;
            r_d = R_DATA;
          end else if (pc_q != PRE_BYTES) begin
            pc_d = pc_q + 1'b1;
          end
        end
        if (!i_rx10_active) r_d = R_IDLE;
      end
      R_DATA: begin
        push = i_rx10_valid;
        if (!i_rx10_active) r_d = R_IDLE;
      end
      default: r_d = R_IDLE;
    endcase
  end

  assign rx_in.data = rb;
  assign rx_in.valid = push;
  assign o_rx10_in_ready = rx_in.ready;
  assign rx_out.ready = i_rx10_ready;
  assign o_rx10_data = rx_out.data;
  assign o_rx10_valid = rx_out.valid;

  lc_skid_fifo #(.W(8), .DEPTH(2)) u_rx10_buf (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .s_in(rx_in),
    .s_out(rx_out)
  );

  // gig receive: cancel, deskew, order, polarity, seed
  logic signed [LVL_W-1:0] own [4];
  logic signed [LVL_W-1:0] lvl [4];
  logic signed [LVL_W-1:0] dly_q [4][SKEW_MAX];
  logic signed [LVL_W-1:0] al [4];
  logic signed [LVL_W-1:0] lg [4];
  align_st_t a_q, a_d;
  logic [3:0] seen_q, seen_d, apol_q, apol_d;
  logic [SKW-1:0] t_q [4];
  logic [SKW-1:0] t_d [4];
  logic [SKW-1:0] sel_q [4];
  logic [SKW-1:0] sel_d [4];
  logic [SKW-1:0] ac_q, ac_d;
  logic swab_q, swab_d, swcd_q, swcd_d;
  logic [G_LFSR_W-1:0] glr_q, glr_d;
  logic [23:0] gr;
  logic [11:0] lgp;
  logic [SYM_W-1:0] rsym;
  logic [7:0] gb_d;
  logic gv_d, mk;

  assign own = '{o_line_pair_a, o_line_pair_b, o_line_pair_c, o_line_pair_d};

  lc_xtalk_cancel u_cancel (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_smp(i_rx_smp),
    .i_own(own),
    .o_lvl(lvl)
  );

  always_comb begin
    a_d = a_q;
    seen_d = seen_q;
    apol_d = apol_q;
    t_d = t_q;
    sel_d = sel_q;
    ac_d = ac_q;
    swab_d = swab_q;
    swcd_d = swcd_q;
    glr_d = glr_q;
    gb_d = o_grx_byte;
    gv_d = 1'b0;
    gr = g_step(glr_q);
    for (int p = 0; p < 4; p++) begin
      al[p] = (sel_q[p] == '0) ? lvl[p] : dly_q[p][sel_q[p] - 1'b1];
      al[p] = apol_q[p] ? -al[p] : al[p];
    end
    lg[0] = swab_q ? al[1] : al[0];
    lg[1] = swab_q ? al[0] : al[1];
    lg[2] = swcd_q ? al[3] : al[2];
    lg[3] = swcd_q ? al[2] : al[3];
    lgp = {lg[3], lg[2], lg[1], lg[0]};
    mk = lgp == MARK_LVLS;
    rsym = pam_dec(lgp);
    case (a_q)
      A_SEEK: begin
        if (|seen_q) ac_d = ac_q + 1'b1;
        for (int p = 0; p < 4; p++) begin
          if (!seen_q[p] && lvl[p] != 3'sh0) begin
            seen_d[p] = 1'b1;
            t_d[p] = ac_q;
            apol_d[p] = lvl[p] < 3'sh0;
            if (p == 0) swab_d = lvl[p] == LVL_P1 || lvl[p] == -LVL_P1;
            if (p == 2) swcd_d = lvl[p] == LVL_P2 || lvl[p] == -LVL_P2;
          end
        end
        if (&seen_d) begin
          for (int p = 0; p < 4; p++) sel_d[p] = ac_q - t_d[p];
          ac_d = '0;
          a_d = A_SEED;
        end else if (ac_q == SKW'(SKEW_MAX-1)) begin
          // skew past the window: start over
          seen_d = 4'h0;
          ac_d = '0;
        end
      end
      A_SEED: begin
        // idle data is zero, so each symbol hands over one key byte
        glr_d = {glr_q[7:0], rsym[7:0]};
        ac_d = ac_q + 1'b1;
        if (ac_q != '0) a_d = A_LOCK;
      end
      A_LOCK: begin
        if (!mk) begin
          glr_d = gr[23:8];
          gb_d = rsym[7:0] ^ gr[7:0];
          gv_d = !rsym[8];
        end
      end
      default: a_d = A_SEEK;
    endcase
    if (spd != SPD_1000) begin
      a_d = A_SEEK;
      seen_d = 4'h0;
      ac_d = '0;
      gv_d = 1'b0;
    end
  end

  // mapping and crossover
  logic xo_d;
  logic signed [LVL_W-1:0] pa_d, pb_d, pc2_d, pd_d;
  always_comb begin
    xo_d = i_xover_disable ? i_crossover_select : px_s;
    if (spd == SPD_1000) begin
      {pd_d, pc2_d, pb_d, pa_d} = tlv_q;
    end else begin
      pa_d = o_crossed ? 3'sh0 : i_fe_tx_lvl;
      pb_d = o_crossed ? i_fe_tx_lvl : 3'sh0;
      pc2_d = 3'sh0;
      pd_d = 3'sh0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cap_q <= 1'b0;
      addr_q <= '0;
      glt_q <= G_RST;
      mg_q <= '0;
      tlv_q <= 12'h000;
      scr_q <= SCR_SEED;
      dsc_q <= SCR_SEED;
      dcnt_q <= 2'h0;
      dlk_q <= 1'b0;
      o_tx_code <= '0;
      o_rx_code <= IDLE_CODE;
      r_q <= R_IDLE;
      pc_q <= 3'h0;
      pol_q <= 1'b0;
      dv_q <= '0;
      rck_q <= 1'b0;
      a_q <= A_SEEK;
      seen_q <= 4'h0;
      apol_q <= 4'h0;
      ac_q <= '0;
      swab_q <= 1'b0;
      swcd_q <= 1'b0;
      glr_q <= G_RST;
      o_grx_byte <= 8'h00;
      o_grx_valid <= 1'b0;
      o_line_pair_a <= 3'sh0;
      o_line_pair_b <= 3'sh0;
      o_line_pair_c <= 3'sh0;
      o_line_pair_d <= 3'sh0;
      o_pair_active <= 4'h0;
      o_crossed <= 1'b0;
      o_fe_rx_lvl <= 3'sh0;
      o_tx_clk_recovered <= 1'b0;
      for (int p = 0; p < 4; p++) begin
        t_q[p] <= '0;
        sel_q[p] <= '0;
        for (int k = 0; k < SKEW_MAX; k++) dly_q[p][k] <= 3'sh0;
      end
    end else begin
      cap_q <= cap_d;
      addr_q <= addr_d;
      glt_q <= glt_d;
      mg_q <= mg_d;
      tlv_q <= tlv_d;
      scr_q <= scr_d;
      dsc_q <= dsc_d;
      dcnt_q <= dcnt_d;
      dlk_q <= dlk_d;
      o_tx_code <= txc_d;
      o_rx_code <= rxc_d;
      r_q <= r_d;
      pc_q <= pc_d;
      pol_q <= pol_d;
      dv_q <= dv_d;
      rck_q <= rck_d;
      a_q <= a_d;
      seen_q <= seen_d;
      apol_q <= apol_d;
      ac_q <= ac_d;
      swab_q <= swab_d;
      swcd_q <= swcd_d;
      glr_q <= glr_d;
      o_grx_byte <= gb_d;
      o_grx_valid <= gv_d;
      t_q <= t_d;
      sel_q <= sel_d;
      o_line_pair_a <= pa_d;
      o_line_pair_b <= pb_d;
      o_line_pair_c <= pc2_d;
      o_line_pair_d <= pd_d;
      o_pair_active <= (spd == SPD_1000) ? 4'hF : 4'h3;
      o_crossed <= xo_d;
      o_fe_rx_lvl <= o_crossed ? lvl[0] : lvl[1];
      // slave clocks its transmitter from the recovered clock
      o_tx_clk_recovered <= spd == SPD_1000 && i_gig_slave;
      for (int p = 0; p < 4; p++) begin
        dly_q[p][0] <= lvl[p];
        for (int k = 1; k < SKEW_MAX; k++) dly_q[p][k] <= dly_q[p][k-1];
      end
    end
  end

  assign o_rx_locked = dlk_q;
  assign o_rx10_clk = rck_q;
  assign o_rx10_pol_inv = pol_q;
  assign o_grx_locked = a_q == A_LOCK;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  property p_scr_only_100;
    (spd != SPD_100) |=> $stable(scr_q);
  endproperty
  a_scr_only_100: assert property (p_scr_only_100) else $error("scrambler moved");
  property p_scr_nonzero;
    scr_q != '0;
  endproperty
  a_scr_nonzero: assert property (p_scr_nonzero) else $error("scrambler stuck");
  property p_dscr_lock;
    (spd == SPD_100 && i_rx_code_idle) [*3] |=> o_rx_locked;
  endproperty
  a_dscr_lock: assert property (p_dscr_lock) else $error("descrambler no lock");
  property p_tx_code;
    (spd == SPD_100) |=> o_tx_code == (($past(i_tx_en) ? enc4b5b($past(i_tx_nib))
      : IDLE_CODE) ^ $past(sc[4:0]));
  endproperty
  a_tx_code: assert property (p_tx_code) else $error("bad code group");
  property p_sfd_first;
    (r_q == R_PRE && push) |-> rb == SFD_BYTE ##1 r_q == R_DATA;
  endproperty
  a_sfd_first: assert property (p_sfd_first) else $error("frame not on sfd");
  property p_rx10_clk;
    $changed(o_rx10_clk) |=> $stable(o_rx10_clk) [*2];
  endproperty
  a_rx10_clk: assert property (p_rx10_clk) else $error("rx clock too fast");
  property p_squelch;
    (r_q == R_IDLE && !sq_s) |=> r_q == R_IDLE;
  endproperty
  a_squelch: assert property (p_squelch) else $error("decode w/o squelch");
  property p_pol;
    (r_q == R_PRE && pc_q == 3'h0 && i_rx10_valid && rx_in.ready
      && i_rx10_byte == PRE_BYTE_INV) |=> o_rx10_pol_inv;
  endproperty
  a_pol: assert property (p_pol) else $error("polarity missed");
  property p_slave_clk;
    (spd == SPD_1000 && i_gig_slave) |=> o_tx_clk_recovered;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("slave clock");
  property p_seed;
    (cap_q && !$past(cap_q)) |-> glt_q == seed_of(addr_q) && addr_q[4:3] == 2'b00;
  endproperty
  a_seed: assert property (p_seed) else $error("bad seed");
  property p_align;
    o_grx_valid |-> $past(a_q) == A_LOCK;
  endproperty
  a_align: assert property (p_align) else $error("data before align");
  property p_xover;
    i_xover_disable |=> o_crossed == $past(i_crossover_select);
  endproperty
  a_xover: assert property (p_xover) else $error("forced mapping");
  c_frame10: cover property (r_q == R_PRE ##[1:20] r_q == R_DATA);
  c_dlock: cover property ($rose(o_rx_locked));
  c_glock: cover property ($rose(o_grx_locked) ##[1:40] o_grx_valid);
endmodule
`default_nettype wire

// ==== phy_lp_model.sv ====
// far side model: one 10 Mb/s frame as decoded bytes
`timescale 1ns/1ps
`default_nettype none
module phy_lp_model (
  // clock and control
  input wire logic i_clk_sys,
  input wire logic i_go,
  input wire logic i_inv,
  // byte stream
  input wire logic i_ready,
  output logic o_active,
  output logic [7:0] o_byte,
  output logic o_valid
);
  int n = 0;
  logic [7:0] last = 8'h00;
  logic [7:0] b;
  // four idle lead-in cycles let the squelch sync settle
  always @(posedge i_clk_sys) begin
    if (!i_go) begin
      n <= 0;
    end else if (n < 4 || (o_valid && i_ready)) begin
      n <= n + 1;
    end
    if (o_valid) begin
      last <= o_byte;
    end
  end
  assign b = (n < 11) ? 8'h55 : (n == 11) ? 8'hD5 : 8'(n);
  assign o_active = i_go && n < 16;
  assign o_valid = o_active && n >= 4;
  // released bus shows the inverse of the last byte
  assign o_byte = o_valid ? (b ^ {8{i_inv}}) : ~last;
endmodule
`default_nettype wire

// ==== phy_line_coding_crossover_tb_top.sv ====
// testbench for the line coding block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module phy_line_coding_crossover_tb_top;
  import phy_lc_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic [1:0] spd = 2'h0;
  logic slave = 1'b0, xdis = 1'b0, xsel = 1'b0, pcr = 1'b0, en = 1'b0, idl = 1'b0;
  logic sq = 1'b0, go = 1'b0, inv = 1'b0, rdy = 1'b0, lck, act, vin, irdy, v10, c10, pinv, cr, rec;
  logic signed [SMP_W-1:0] smp [4];
  logic signed [LVL_W-1:0] fe = 3'sh1;
  logic signed [LVL_W-1:0] la, lb, lc, ld;
  logic gv = 1'b0, grv, glk;
  logic [7:0] gb = 8'h00, grb;
  logic [CODE_W-1:0] txc, rxc;
  logic [7:0] byt, d10;
  logic [3:0] pact;
  int errors = 0;
  int checked = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  // flags the group now on o_tx_code as idle
  always @(posedge i_clk_sys) idl <= !en;
  // far end loops our levels back; echo and crosstalk leak in on top
  always_comb begin
    smp[0] = 8'(36 * la + 2 * (lb + lc + ld));
    smp[1] = 8'(36 * lb + 2 * (la + lc + ld));
    smp[2] = 8'(36 * lc + 2 * (la + lb + ld));
    smp[3] = 8'(36 * ld + 2 * (la + lb + lc));
  end
  phy_line_coding_crossover dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_speed(spd),
    .i_gig_slave(slave), .i_mgmt_addr_straps(3'h5), .i_xover_disable(xdis),
    .i_crossover_select(xsel), .i_partner_crossed(pcr), .i_tx_nib(4'h0), .i_tx_en(en),
    .o_tx_code(txc), .i_rx_code(txc), .i_rx_code_idle(idl), .o_rx_code(rxc),
    .o_rx_locked(lck), .i_squelch_ok(sq), .i_rx10_active(act), .i_rx10_byte(byt),
    .i_rx10_valid(vin), .o_rx10_in_ready(irdy), .o_rx10_data(d10), .o_rx10_valid(v10),
    .i_rx10_ready(rdy), .o_rx10_clk(c10), .o_rx10_pol_inv(pinv), .i_gtx_byte(gb),
    .i_gtx_valid(gv), .i_rx_smp(smp), .o_grx_byte(grb), .o_grx_valid(grv), .o_grx_locked(glk),
    .i_fe_tx_lvl(fe), .o_fe_rx_lvl(), .o_line_pair_a(la), .o_line_pair_b(lb),
    .o_line_pair_c(lc), .o_line_pair_d(ld), .o_pair_active(pact), .o_crossed(cr),
    .o_tx_clk_recovered(rec));
  phy_lp_model lp (.i_clk_sys(i_clk_sys), .i_go(go), .i_inv(inv), .i_ready(irdy),
    .o_active(act), .o_byte(byt), .o_valid(vin));

  // more than one full 2047 period; loopback also checks the descrambler
  task automatic t_scr();
    logic [10:0] s;
    logic [4:0] k, p, pp;
    s = 11'h7FF;
    pp = 5'h1F;
    @(posedge i_clk_sys);
    spd <= 2'h1;
    for (int g = 0; g < 2100; g++) begin
      @(posedge i_clk_sys);
      p = en ? 5'h1E : 5'h1F;
      en <= (g > 7) && !g[0];
      #1;
      for (int i = 4; i >= 0; i--) begin
        k[i] = s[10] ^ s[8];
        s = {s[9:0], k[i]};
      end
      `CHK(txc, p ^ k)
      if (g > 11) `CHK({lck, rxc}, {1'b1, pp})
      pp = p;
    end
    $display("test scrambler done");
  endtask

  task automatic t_rx10(input logic sqv, input logic iv);
    logic [7:0] eb [5] = '{8'hD5, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
    int n = 0;
    @(posedge i_clk_sys);
    spd <= 2'h0;
    sq <= sqv;
    inv <= iv;
    repeat (8) @(posedge i_clk_sys);
    go <= 1'b1;
    for (int c = 0; c < 150; c++) begin
      @(posedge i_clk_sys);
      if (v10 && rdy) begin
        if (n < 5) `CHK(d10, eb[n])
        n++;
      end
      rdy <= c[0] | c[2];
    end
    `CHK(n, sqv ? 5 : 0)
    `CHK(txc, 5'h00)
    if (sqv) `CHK(pinv, iv)
    go <= 1'b0;
    $display("test rx10 done");
  endtask

  // receive clock keeps toggling with no frame
  task automatic t_clk10();
    logic p;
    int t = 0;
    @(posedge i_clk_sys);
    p = c10;
    repeat (200) begin
      @(posedge i_clk_sys);
      t += int'(c10 != p);
      p = c10;
    end
    `CHK(t, 5)
    $display("test rx clock done");
  endtask

  task automatic t_map();
    @(posedge i_clk_sys);
    `CHK({cr, la, lb}, 7'h08)
    pcr <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    `CHK({cr, pact}, 5'h13)
    `CHK({la, lb}, 6'h01)
    xdis <= 1'b1;
    fe <= 3'sh0;
    repeat (3) @(posedge i_clk_sys);
    `CHK(cr, 1'b0)
    xsel <= 1'b1;
    pcr <= 1'b0;
    spd <= 2'h2;
    slave <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    `CHK({cr, rec, pact}, 6'h3F)
    $display("test mapping done");
  endtask

  // gig loopback: align on idle, then four data bytes come back in order
  task automatic t_gig();
    int n = 0;
    repeat (20) @(posedge i_clk_sys);
    `CHK(glk, 1'b1)
    for (int c = 0; c < 40; c++) begin
      @(posedge i_clk_sys);
      if (grv) begin
        `CHK(grb, 8'(8'hA0 + n))
        n++;
      end
      gv <= (c < 4);
      gb <= 8'(8'hA0 + c);
    end
    `CHK(n, 4)
    $display("test gig done");
  endtask

  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    t_scr();
    t_rx10(1'b1, 1'b0);
    t_rx10(1'b0, 1'b0);
    t_rx10(1'b1, 1'b1);
    t_clk10();
    t_map();
    t_gig();
    results();
  end
endmodule
`default_nettype wire
